// file: sensor_twi_slave.sv
// Two-wire slave interface of the temperature sensor.
//
// Contract
// - First byte holds seven address bits then direction; low writes.
// - Own address is acknowledged by pulling data low in ninth pulse.
// - Each byte is eight pulses plus one acknowledge from the receiver.
// - Data changes only with clock low; high-clock changes are START/STOP.
// - Three-level straps map to one of 27 fixed seven-bit addresses.
// - Binary straps give the low three address bits, 1001000 to 1001111.
// - Straps are latched after reset, at START and on address acquire.
// - First byte of every write loads the register pointer.
// - Reads use the last written pointer, kept until the next write.
// - Register words move most significant byte first.
// - As receiver, acknowledge address, pointer and every data byte.
// - START or STOP at any byte boundary abandons the transfer.
// - Read sends high then low byte; master ends with NACK, START, STOP.
// - With interrupt style and alert active, answer alert response.
// - Returned address ends high above upper limit, low below lower.
// - Arbitrate the returned address; clear alert only when winning.
// - Acknowledge general call address with write bit; next byte commands.
// - Command 04 relatches straps; command 06 also resets registers.
// - Master code 00001xxx is not acknowledged but selects high-speed filters.
// - High-speed stays over repeated STARTs and ends at STOP.
// - Pointer bits one and zero select temperature, config, low, high.
// - Pointer powers up as 00, selecting the temperature register.
`timescale 1ns/100ps
module sensor_twi_slave
    import sensor_twi_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n_o,
    input  wire logic [1:0]  addr_strap_bit_zero_i,
    input  wire logic [1:0]  addr_strap_bit_one_i,
    input  wire logic [1:0]  addr_strap_bit_two_i,
    input  wire logic        addr_mode_27_i,
    input  wire logic        thermostat_style_select_i,
    input  wire logic        alert_active_i,
    input  wire logic        alert_high_i,
    input  wire logic [15:0] rd_word_i,
    output logic [1:0]       register_select_bits_o,
    output logic [6:0]       slave_addr_o,
    output logic             wr_strobe_o,
    output logic [7:0]       wr_data_o,
    output logic             wr_msb_o,
    output logic             rd_strobe_o,
    output logic             alert_clear_o,
    output logic             soft_reset_o,
    output logic             hs_mode_o
);

    typedef struct packed {
        logic [6:0]     strap_s1;
        logic [6:0]     strap_s2;
        logic           scl_s1;
        logic           scl_s2;
        logic           sda_s1;
        logic           sda_s2;
        logic           scl_f;
        logic           sda_f;
        logic [3:0]     scl_cnt;
        logic [3:0]     sda_cnt;
        logic [1:0]     boot_cnt;
        link_state_type ls;
        logic [3:0]     bit_cnt;
        logic [7:0]     rx;
        logic [7:0]     tx;
        logic           mack_n;
        logic           byte_lsb;
        logic [6:0]     own_addr;
        logic [1:0]     ptr;
        logic           hs;
        logic           sda_oe_n;
        logic           sda_out;
        logic           wr_stb;
        logic [7:0]     wr_data;
        logic           wr_msb;
        logic           rd_stb;
        logic           alert_clr;
        logic           soft_rst;
    } state_type;

    state_type  st;
    state_type  next_st;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_ev;
    logic       stop_ev;
    logic [3:0] lim;

    // -----------------------------------------------------------------
    // Strap decoding
    // -----------------------------------------------------------------
    function automatic logic [6:0] map_addr(input logic [6:0] s);
        logic [5:0] k;
        k[5:4] = s[5] ? LVL_FLOAT : {1'b0, s[4]};
        k[3:2] = s[3] ? LVL_FLOAT : {1'b0, s[2]};
        k[1:0] = s[1] ? LVL_FLOAT : {1'b0, s[0]};
        map_addr = {BIN_ADDR_TOP, s[4], s[2], s[0]};
        if (s[6]) begin
            case (k)
                6'h20:   map_addr = 7'h70;
                6'h22:   map_addr = 7'h71;
                6'h21:   map_addr = 7'h72;
                6'h24:   map_addr = 7'h73;
                6'h26:   map_addr = 7'h74;
                6'h25:   map_addr = 7'h75;
                6'h28:   map_addr = 7'h76;
                6'h29:   map_addr = 7'h77;
                6'h08:   map_addr = 7'h28;
                6'h09:   map_addr = 7'h29;
                6'h18:   map_addr = 7'h2a;
                6'h19:   map_addr = 7'h2b;
                6'h02:   map_addr = 7'h2c;
                6'h06:   map_addr = 7'h2d;
                6'h12:   map_addr = 7'h2e;
                6'h16:   map_addr = 7'h2f;
                6'h0a:   map_addr = 7'h35;
                6'h1a:   map_addr = 7'h36;
                6'h2a:   map_addr = 7'h37;
                default: map_addr = {BIN_ADDR_TOP, k[4], k[2], k[0]};
            endcase
        end
    endfunction

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.wr_stb    = 1'b0;
        next_st.rd_stb    = 1'b0;
        next_st.alert_clr = 1'b0;
        next_st.soft_rst  = 1'b0;
        next_st.sda_out   = 1'b0;
        next_st.strap_s1  = {addr_mode_27_i, addr_strap_bit_two_i,
                             addr_strap_bit_one_i, addr_strap_bit_zero_i};
        next_st.strap_s2  = st.strap_s1;
        next_st.scl_s1    = scl_i;
        next_st.scl_s2    = st.scl_s1;
        next_st.sda_s1    = sda_i;
        next_st.sda_s2    = st.sda_s1;
        // Spike filter length follows the speed mode.
        lim = st.hs ? 4'(SPIKE_HS_CYC - 1) : 4'(SPIKE_FAST_CYC - 1);
        next_st.scl_cnt = 4'h0;
        next_st.sda_cnt = 4'h0;
        if (st.scl_s2 != st.scl_f) begin
            next_st.scl_cnt = st.scl_cnt + 4'h1;
            if (st.scl_cnt >= lim) begin
                next_st.scl_f   = st.scl_s2;
                next_st.scl_cnt = 4'h0;
            end
        end
        if (st.sda_s2 != st.sda_f) begin
            next_st.sda_cnt = st.sda_cnt + 4'h1;
            if (st.sda_cnt >= lim) begin
                next_st.sda_f   = st.sda_s2;
                next_st.sda_cnt = 4'h0;
            end
        end
        scl_rise = !st.scl_f && next_st.scl_f;
        scl_fall = st.scl_f && !next_st.scl_f;
        // Data edges with clock high are control events.
        start_ev = st.scl_f && next_st.scl_f && st.sda_f && !next_st.sda_f;
        stop_ev  = st.scl_f && next_st.scl_f && !st.sda_f && next_st.sda_f;
        // Latch straps once the synchroniser has settled.
        if (st.boot_cnt != BOOT_DONE) begin
            next_st.boot_cnt = st.boot_cnt + 2'h1;
            next_st.own_addr = map_addr(st.strap_s2);
        end
        if (start_ev) begin
            // Start, also repeated, restarts the transfer.
            next_st.ls       = LS_ADDR;
            next_st.bit_cnt  = 4'h0;
            next_st.sda_oe_n = 1'b1;
            next_st.own_addr = map_addr(st.strap_s2);
        end else if (stop_ev) begin
            // Stop ends the transfer; back to fast mode.
            next_st.ls       = LS_IDLE;
            next_st.sda_oe_n = 1'b1;
            next_st.hs       = 1'b0;
        end else if (st.ls != LS_IDLE) begin
            if (scl_rise) begin
                if (st.bit_cnt < BYTE_DONE) begin
                    next_st.rx = {st.rx[6:0], next_st.sda_f};
                end else begin
                    next_st.mack_n = next_st.sda_f;
                end
                // Lost arbitration while sending a released one.
                if (st.ls == LS_ARA && st.bit_cnt < BYTE_DONE &&
                    st.tx[7] && !next_st.sda_f) begin
                    next_st.ls       = LS_SKIP;
                    next_st.sda_oe_n = 1'b1;
                end
                next_st.bit_cnt = st.bit_cnt + 4'h1;
            end
            if (scl_fall) begin
                if (st.bit_cnt == BYTE_DONE) begin
                    next_st.sda_oe_n = 1'b1;
                    case (st.ls)
                        LS_ADDR: begin
                            next_st.byte_lsb = 1'b0;
                            next_st.ls       = LS_SKIP;
                            if (st.rx[7:1] == st.own_addr) begin
                                next_st.sda_oe_n = 1'b0;
                                next_st.ls = st.rx[0] ? LS_RDATA : LS_PTR;
                            end else if (st.rx == GCALL_WRITE) begin
                                next_st.sda_oe_n = 1'b0;
                                next_st.ls       = LS_GCMD;
                            end else if (st.rx == ALERT_RESP &&
                                         thermostat_style_select_i &&
                                         alert_active_i) begin
                                next_st.sda_oe_n = 1'b0;
                                next_st.ls       = LS_ARA;
                            end else if (st.rx[7:3] == HS_CODE_TOP) begin
                                next_st.hs = 1'b1;
                            end
                        end
                        LS_PTR: begin
                            next_st.ptr      = st.rx[1:0];
                            next_st.sda_oe_n = 1'b0;
                            next_st.ls       = LS_WDATA;
                        end
                        LS_WDATA: begin
                            next_st.sda_oe_n = 1'b0;
                            next_st.wr_stb   = 1'b1;
                            next_st.wr_data  = st.rx;
                            next_st.wr_msb   = !st.byte_lsb;
                            next_st.byte_lsb = !st.byte_lsb;
                        end
                        LS_GCMD: begin
                            next_st.ls = LS_SKIP;
                            if (st.rx == GC_RELATCH || st.rx == GC_RESET) begin
                                next_st.sda_oe_n = 1'b0;
                                next_st.own_addr = map_addr(st.strap_s2);
                            end
                            if (st.rx == GC_RESET) begin
                                next_st.soft_rst = 1'b1;
                                next_st.ptr      = PTR_RESET;
                            end
                        end
                        LS_ARA: begin
                            next_st.alert_clr = st.byte_lsb;
                        end
                        default: begin
                            next_st.sda_oe_n = 1'b1;
                        end
                    endcase
                end else if (st.bit_cnt == ACK_DONE) begin
                    // Ninth pulse over, next byte begins.
                    next_st.bit_cnt  = 4'h0;
                    next_st.sda_oe_n = 1'b1;
                    if (st.ls == LS_RDATA) begin
                        if (!st.sda_oe_n || !st.mack_n) begin
                            next_st.tx = st.byte_lsb ? rd_word_i[7:0]
                                                     : rd_word_i[15:8];
                            next_st.rd_stb   = !st.byte_lsb;
                            next_st.byte_lsb = !st.byte_lsb;
                            next_st.sda_oe_n = next_st.tx[7];
                        end else begin
                            next_st.ls = LS_SKIP;
                        end
                    end else if (st.ls == LS_ARA) begin
                        if (st.byte_lsb) begin
                            next_st.ls = LS_SKIP;
                        end else begin
                            // Own address with limit side bit.
                            next_st.tx       = {st.own_addr, alert_high_i};
                            next_st.byte_lsb = 1'b1;
                            next_st.sda_oe_n = next_st.tx[7];
                        end
                    end
                end else if ((st.ls == LS_RDATA || st.ls == LS_ARA) &&
                             st.bit_cnt != 4'h0) begin
                    next_st.tx       = {st.tx[6:0], 1'b0};
                    next_st.sda_oe_n = st.tx[6];
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // State register
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Pointer and control state cleared; filters, mack_n and sda_oe_n idle high.
            st          <= '0;
            st.scl_s1   <= 1'b1;
            st.scl_s2   <= 1'b1;
            st.sda_s1   <= 1'b1;
            st.sda_s2   <= 1'b1;
            st.scl_f    <= 1'b1;
            st.sda_f    <= 1'b1;
            st.mack_n   <= 1'b1;
            st.sda_oe_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign sda_o                  = st.sda_out;
    assign sda_oe_n_o             = st.sda_oe_n;
    assign register_select_bits_o = st.ptr;
    assign slave_addr_o           = st.own_addr;
    assign wr_strobe_o            = st.wr_stb;
    assign wr_data_o              = st.wr_data;
    assign wr_msb_o               = st.wr_msb;
    assign rd_strobe_o            = st.rd_stb;
    assign alert_clear_o          = st.alert_clr;
    assign soft_reset_o           = st.soft_rst;
    assign hs_mode_o              = st.hs;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    own_addr_ack_a: assert property (
        st.ls == LS_ADDR && scl_fall && st.bit_cnt == BYTE_DONE &&
        st.rx[7:1] == st.own_addr |=> !st.sda_oe_n [*2])
        else $error("own address not acknowledged");
    foreign_nack_a: assert property (
        st.ls == LS_ADDR && scl_fall && st.bit_cnt == BYTE_DONE &&
        st.rx[7:1] != st.own_addr && st.rx != GCALL_WRITE &&
        st.rx != ALERT_RESP |=> st.sda_oe_n && st.ls == LS_SKIP)
        else $error("foreign address acknowledged");
    ptr_load_a: assert property (
        st.ls == LS_PTR && scl_fall && st.bit_cnt == BYTE_DONE
        |=> st.ptr == $past(st.rx[1:0]) && st.ls == LS_WDATA)
        else $error("pointer not loaded");
    start_abort_a: assert property (
        start_ev |=> st.ls == LS_ADDR && st.bit_cnt == 4'h0 && st.sda_oe_n)
        else $error("start did not restart transfer");
    hs_stop_a: assert property (
        stop_ev |=> !st.hs && st.ls == LS_IDLE)
        else $error("stop left high-speed mode");
    hs_enter_a: assert property (
        st.ls == LS_ADDR && scl_fall && st.bit_cnt == BYTE_DONE &&
        st.rx[7:3] == HS_CODE_TOP |=> st.hs && st.sda_oe_n)
        else $error("master code mishandled");
    gc_reset_a: assert property (
        st.ls == LS_GCMD && scl_fall && st.bit_cnt == BYTE_DONE &&
        st.rx == GC_RESET |=> st.soft_rst && st.ptr == PTR_RESET)
        else $error("general call reset missed");
    msb_first_a: assert property (
        $rose(st.rd_stb) |-> st.tx == $past(rd_word_i[15:8]))
        else $error("high byte not sent first");
    ara_reply_a: assert property (
        st.ls == LS_ARA && scl_fall && st.bit_cnt == ACK_DONE &&
        !st.byte_lsb |=> st.tx == {st.own_addr, $past(alert_high_i)})
        else $error("alert response address wrong");
    wr_data_a: assert property (
        st.ls == LS_WDATA && scl_fall && st.bit_cnt == BYTE_DONE
        |=> st.wr_stb && st.wr_data == $past(st.rx) && !st.sda_oe_n)
        else $error("data byte not written");

endmodule

// file: sensor_twi_pkg.sv
// Constants and types shared by the sensor two-wire slave interface.
package sensor_twi_pkg;

    localparam int CLK_MHZ       = 200;
    localparam int SPIKE_FAST_NS = 50;
    localparam int SPIKE_HS_NS   = 10;
    localparam int SPIKE_FAST_CYC =
        (SPIKE_FAST_NS * CLK_MHZ / 1000 < 1) ? 1 :
        SPIKE_FAST_NS * CLK_MHZ / 1000;
    localparam int SPIKE_HS_CYC =
        (SPIKE_HS_NS * CLK_MHZ / 1000 < 1) ? 1 :
        SPIKE_HS_NS * CLK_MHZ / 1000;

    localparam logic [3:0] BYTE_DONE    = 4'h8;
    localparam logic [3:0] ACK_DONE     = 4'h9;
    localparam logic [1:0] BOOT_DONE    = 2'h3;
    localparam logic [1:0] PTR_RESET    = 2'h0;
    localparam logic [7:0] GCALL_WRITE  = 8'h00;
    localparam logic [7:0] ALERT_RESP   = 8'h19;
    localparam logic [7:0] GC_RELATCH   = 8'h04;
    localparam logic [7:0] GC_RESET     = 8'h06;
    localparam logic [4:0] HS_CODE_TOP  = 5'h01;
    localparam logic [3:0] BIN_ADDR_TOP = 4'h9;
    localparam logic [1:0] LVL_FLOAT    = 2'h2;

    typedef enum logic [2:0] {
        LS_IDLE  = 3'b000,
        LS_ADDR  = 3'b001,
        LS_PTR   = 3'b010,
        LS_WDATA = 3'b011,
        LS_RDATA = 3'b100,
        LS_GCMD  = 3'b101,
        LS_ARA   = 3'b110,
        LS_SKIP  = 3'b111
    } link_state_type;

endpackage

// file: sensor_twi_master_model.sv
// Bus master model that drives the two-wire link for the bench.
`timescale 1ns/100ps
module sensor_twi_master_model (
    input  wire logic sda_i,
    output logic      scl_o = 1'b1,
    output logic      sda_o = 1'b1
);
    // ----------------------------------------------------------------
    // Bit, byte and framing timing.
    // ----------------------------------------------------------------
    realtime q = 80.0;

    task automatic send_bit(input logic b, output logic s);
        #q sda_o = b;
        #q scl_o = 1'b1;
        #q s = sda_i;
        #q scl_o = 1'b0;
    endtask

    task automatic xfer(input logic [7:0] tx, input logic last,
                        output logic [7:0] rx, output logic ninth);
        for (int i = 7; i >= 0; i--) send_bit(tx[i], rx[i]);
        send_bit(last, ninth);
    endtask

    task automatic start();
        #q sda_o = 1'b1;
        #q scl_o = 1'b1;
        #q sda_o = 1'b0;
        #q scl_o = 1'b0;
    endtask

    task automatic stop();
        #q sda_o = 1'b0;
        #q scl_o = 1'b1;
        #q sda_o = 1'b1;
        #q;
    endtask
endmodule

// file: sensor_two_wire_slave_interface_bench.sv
// Self-checking bench for the sensor two-wire slave interface.
`timescale 1ns/100ps
module sensor_two_wire_slave_interface_bench;
    // ----------------------------------------------------------------
    // Stimulus, monitors and checks.
    // ----------------------------------------------------------------
    logic        ref_clk_i = 1'b0, rst_n_i = 1'b0, scl, m_sda, nine;
    logic        mode27 = 1'b0, tstyle = 1'b0, act = 1'b0, hi = 1'b0;
    logic        sda_o, sda_oe_n, wr_strobe, wr_msb, rd_strobe;
    logic        alert_clear, soft_reset, hs_mode;
    logic [1:0]  a0 = 2'h0, a1 = 2'h0, a2 = 2'h0, ptr;
    logic [15:0] rd_word = 16'h0, d;
    logic [6:0]  slave_addr, own;
    logic [7:0]  wr_data, rx;
    logic [8:0]  wq[$];
    int          fails = 0, tests_run = 0, n_rd = 0, n_clr = 0, n_rst = 0;
    int          seed = 32'h4d7723f5;
    wire         sda_line = m_sda & (sda_oe_n | sda_o);
    logic [6:0]  map27 [27] = '{7'h48, 7'h49, 7'h2c, 7'h4a, 7'h4b, 7'h2d,
        7'h28, 7'h29, 7'h35, 7'h4c, 7'h4d, 7'h2e, 7'h4e, 7'h4f, 7'h2f,
        7'h2a, 7'h2b, 7'h36, 7'h70, 7'h72, 7'h71, 7'h73, 7'h75, 7'h74,
        7'h76, 7'h77, 7'h37};

    always #2.5 ref_clk_i = ~ref_clk_i;

    sensor_twi_slave dut (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
        .addr_strap_bit_zero_i(a0), .addr_strap_bit_one_i(a1),
        .addr_strap_bit_two_i(a2), .addr_mode_27_i(mode27),
        .thermostat_style_select_i(tstyle), .alert_active_i(act),
        .alert_high_i(hi), .rd_word_i(rd_word),
        .register_select_bits_o(ptr), .slave_addr_o(slave_addr),
        .wr_strobe_o(wr_strobe), .wr_data_o(wr_data), .wr_msb_o(wr_msb),
        .rd_strobe_o(rd_strobe), .alert_clear_o(alert_clear),
        .soft_reset_o(soft_reset), .hs_mode_o(hs_mode));

    sensor_twi_master_model master (.sda_i(sda_line), .scl_o(scl),
                                    .sda_o(m_sda));

    always @(posedge ref_clk_i) begin
        if (wr_strobe === 1'b1) wq.push_back({wr_msb, wr_data});
        n_rd  += int'(rd_strobe === 1'b1);
        n_clr += int'(alert_clear === 1'b1);
        n_rst += int'(soft_reset === 1'b1);
    end

    function automatic logic [1:0] lvl(input logic m, input int k,
                                       input int p);
        int v;
        v = m ? (k / ((p == 2) ? 9 : ((p == 1) ? 3 : 1))) % 3 : (k >> p) & 1;
        return (v == 2) ? 2'h2 : 2'(v);
    endfunction

    function automatic logic [6:0] exp_addr(input logic m, input int k);
        return m ? map27[k] : {4'h9, 3'(k)};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] tx, input logic exp_nine);
        master.xfer(tx, 1'b1, rx, nine);
        check(16'(nine), 16'(exp_nine));
    endtask

    task automatic rd(input logic last, input logic [7:0] exp);
        master.xfer(8'hff, last, rx, nine);
        check(16'(rx), 16'(exp));
    endtask

    task automatic set_straps(input logic m, input int k);
        @(negedge ref_clk_i);
        mode27 = m;
        a0 = lvl(m, k, 0);
        a1 = lvl(m, k, 1);
        a2 = lvl(m, k, 2);
        own = exp_addr(m, k);
        repeat (8) @(negedge ref_clk_i);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #450000;
        fails++;
        $display("watchdog expired");
        give_verdict();
    end

    initial begin
        repeat (12) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        repeat (10) @(negedge ref_clk_i);
        check(16'(ptr), 16'h0);
        for (int i = 0; i < 35; i++) begin
            set_straps(i < 27, (i < 27) ? i : i - 27);
            master.start();
            wr({own, 1'b0}, 1'b0);
            master.stop();
            check(16'(slave_addr), 16'(own));
        end
        master.start();
        wr({own ^ 7'h40, 1'b0}, 1'b1);
        master.stop();
        $display("address test done");
        for (int p = 0; p < 4; p++) begin
            d = 16'($random(seed));
            wq = {};
            master.start();
            wr({own, 1'b0}, 1'b0);
            wr(8'(p), 1'b0);
            wr(d[15:8], 1'b0);
            master.start();
            wr({own, 1'b0}, 1'b0);
            wr(8'(p), 1'b0);
            wr(d[15:8], 1'b0);
            wr(d[7:0], 1'b0);
            master.stop();
            check(16'(ptr), 16'(p));
            check(16'(wq.size()), 16'h3);
            check({7'h0, wq[1]}, {8'h1, d[15:8]});
            check({7'h0, wq[2]}, {8'h0, d[7:0]});
        end
        $display("write test done");
        @(negedge ref_clk_i);
        rd_word = 16'($random(seed));
        master.start();
        wr({own, 1'b1}, 1'b0);
        rd(1'b0, rd_word[15:8]);
        rd(1'b1, rd_word[7:0]);
        master.stop();
        check(16'(ptr), 16'h3);
        master.start();
        wr({own, 1'b0}, 1'b0);
        wr(8'h01, 1'b0);
        master.start();
        wr({own, 1'b1}, 1'b0);
        rd(1'b1, rd_word[15:8]);
        master.stop();
        check(16'(n_rd), 16'h2);
        $display("read test done");
        tstyle = 1'b1;
        act = 1'b1;
        for (int j = 0; j < 3; j++) begin
            @(negedge ref_clk_i);
            hi = (j != 0);
            master.start();
            wr(8'h19, 1'b0);
            master.xfer((j == 2) ? {own, 1'b0} : 8'hff, 1'b1, rx, nine);
            master.stop();
            check(16'(rx), 16'({own, j == 1}));
            check(16'(n_clr), 16'((j == 2) ? 2 : j + 1));
        end
        tstyle = 1'b0;
        master.start();
        wr(8'h19, 1'b1);
        master.stop();
        act = 1'b0;
        $display("alert test done");
        set_straps(1'b0, 2);
        master.start();
        wr(8'h00, 1'b0);
        set_straps(1'b0, 5);
        wr(8'h04, 1'b0);
        master.stop();
        check(16'(slave_addr), 16'(own));
        check(16'(n_rst), 16'h0);
        master.start();
        wr(8'h00, 1'b0);
        set_straps(1'b0, 3);
        wr(8'h06, 1'b0);
        master.stop();
        check(16'(slave_addr), 16'(own));
        check(16'(n_rst), 16'h1);
        check(16'(ptr), 16'h0);
        master.start();
        wr(8'h01, 1'b1);
        master.stop();
        $display("general call test done");
        d = 16'($random(seed));
        master.start();
        wr({5'h01, d[2:0]}, 1'b1);
        check(16'(hs_mode), 16'h1);
        master.q = 20.0;
        master.start();
        wr({own, 1'b0}, 1'b0);
        wr(8'h02, 1'b0);
        check(16'(hs_mode), 16'h1);
        master.stop();
        master.q = 80.0;
        repeat (10) @(negedge ref_clk_i);
        check(16'(hs_mode), 16'h0);
        check(16'(ptr), 16'h2);
        $display("high speed test done");
        @(negedge ref_clk_i);
        rst_n_i = 1'b0;
        @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        repeat (5) @(negedge ref_clk_i);
        check(16'(ptr), 16'h0);
        check(16'(slave_addr), 16'(own));
        $display("reset test done");
        give_verdict();
    end
endmodule
